// ==== verilog/csc_defines.vh ====
// Register offsets, field positions, reset values and segment opcodes of the store controller.
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

// ****************************************************************
// Register offsets on the control port address space
// ****************************************************************
`define CSC_ADDR_STATUS     12'hB00
`define CSC_ADDR_ERROR      12'hB01
`define CSC_ADDR_RELOAD     12'hB02
`define CSC_ADDR_STORE_CMD  12'hB03
`define CSC_ADDR_COMMIT     12'h232
`define CSC_ADDR_SEG_FIRST  12'hA00
`define CSC_ADDR_SEG_LAST   12'hA16

// ****************************************************************
// Field positions
// ****************************************************************
`define CSC_BIT_BUSY        0
`define CSC_BIT_ERROR       0
`define CSC_BIT_WR_ENABLE   0
`define CSC_BIT_RELOAD      1
`define CSC_BIT_STORE_GO    0
`define CSC_BIT_COMMIT      0

// ****************************************************************
// Segment list layout and opcodes
// ****************************************************************
`define CSC_SEG_COUNT       23
`define CSC_SEG_BITS        184
`define CSC_OP_END          8'hFF
`define CSC_OP_COMMIT       8'hFE
`define CSC_SEG_DEFAULT     184'hFFFFFFFFFFFFFFFFFFFFFE30020390011FF0000F00001F

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CSC_RST_WR_ENABLE   1'b0
`define CSC_BOOT_WAIT       2'd3

`endif

// ==== verilog/csc_xfer.v ====
// Transfer engine that walks the segment list between buffer bank and store.
`timescale 1ns/1ns
`include "csc_defines.vh"

module csc_xfer (
	input  wire                     clk,
	input  wire                     resetn,
	input  wire                     start,
	input  wire                     save,
	input  wire [`CSC_SEG_BITS-1:0] seg_list,
	output wire                     busy,
	output reg                      done,
	output reg                      err,
	output reg                      commit,
	output reg  [11:0]              buf_raddr,
	input  wire [7:0]               buf_rdata,
	output reg                      buf_we,
	output reg  [11:0]              buf_waddr,
	output reg  [7:0]               buf_wdata,
	output wire                     nv_req,
	output reg                      nv_we,
	output reg  [9:0]               nv_addr,
	output reg  [7:0]               nv_wdata,
	input  wire [7:0]               nv_rdata,
	input  wire                     nv_ack
);

	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_HEAD = 5'b00010;
	localparam [4:0] S_MOVE = 5'b00100;
	localparam [4:0] S_SUM  = 5'b01000;
	localparam [4:0] S_WAIT = 5'b10000;

	reg  [4:0]  state;
	reg         dir_save;
	reg  [4:0]  seg_idx;
	reg  [11:0] base;
	reg  [7:0]  left;
	reg  [7:0]  offset;
	reg  [9:0]  nv_ptr;
	reg  [7:0]  sum;
	wire [7:0]  ctl;
	wire [7:0]  seg_hi;
	wire [7:0]  seg_lo;

	// Byte of the segment list; an index past the end reads as the end opcode.
	function [7:0] seg_byte;
		input [`CSC_SEG_BITS-1:0] list;
		input [4:0]               idx;
		begin
			if (idx >= `CSC_SEG_COUNT)
				seg_byte = `CSC_OP_END;
			else
				seg_byte = list[idx*8 +: 8];
		end
	endfunction

	assign ctl    = seg_byte(seg_list, seg_idx);
	assign seg_hi = seg_byte(seg_list, seg_idx + 5'd1);
	assign seg_lo = seg_byte(seg_list, seg_idx + 5'd2);
	assign busy   = (state != S_IDLE);
	assign nv_req = (state == S_MOVE) | (state == S_SUM);

	// Store-side address and data follow the walk; writes only when saving.
	always @* begin
		buf_raddr = base + {4'h0, offset};
		nv_addr   = nv_ptr;
		nv_we     = dir_save & nv_req;
		nv_wdata  = (state == S_SUM) ? sum : buf_rdata;
	end

	// Main walk. A load compares the trailing sum byte so a corrupted store is flagged.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state     <= S_IDLE;
			dir_save  <= 1'b0;
			seg_idx   <= 5'd0;
			base      <= 12'h000;
			left      <= 8'h00;
			offset    <= 8'h00;
			nv_ptr    <= 10'h000;
			sum       <= 8'h00;
			done      <= 1'b0;
			err       <= 1'b0;
			commit    <= 1'b0;
			buf_we    <= 1'b0;
			buf_waddr <= 12'h000;
			buf_wdata <= 8'h00;
		end else begin
			done   <= 1'b0;
			commit <= 1'b0;
			buf_we <= 1'b0;
			case (state)
			S_IDLE: begin
				if (start) begin
					dir_save <= save;
					seg_idx  <= 5'd0;
					nv_ptr   <= 10'h000;
					sum      <= 8'h00;
					err      <= 1'b0;
					state    <= S_HEAD;
				end
			end
			S_HEAD: begin
				if (ctl == `CSC_OP_END) begin
					state <= S_SUM;
				end else if (ctl == `CSC_OP_COMMIT) begin
					commit  <= ~dir_save;
					seg_idx <= seg_idx + 5'd1;
				end else begin
					base    <= {seg_hi[3:0], seg_lo};
					left    <= ctl;
					offset  <= 8'h00;
					seg_idx <= seg_idx + 5'd3;
					state   <= S_MOVE;
				end
			end
			S_MOVE: begin
				if (nv_ack) begin
					if (!dir_save) begin
						buf_we    <= 1'b1;
						buf_waddr <= buf_raddr;
						buf_wdata <= nv_rdata;
					end
					sum    <= sum ^ (dir_save ? buf_rdata : nv_rdata);
					nv_ptr <= nv_ptr + 10'd1;
					offset <= offset + 8'd1;
					if (left == 8'h00)
						state <= S_HEAD;
					else
						left <= left - 8'd1;
				end
			end
			S_SUM: begin
				if (nv_ack) begin
					err   <= ~dir_save & (nv_rdata != sum);
					state <= S_WAIT;
				end
			end
			S_WAIT: begin
				done  <= 1'b1;
				state <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

endmodule

// ==== verilog/csc_ctrl.v ====
// Control and status registers of the configuration store controller.
`timescale 1ns/1ns
`include "csc_defines.vh"

// Function
// - Status register bit 0 reads 1 while a save or load transfer runs, else 0.
// - Busy flag drives the status pin when the routing bit is set.
// - Error register bit 0 reads 1 when a transfer found bad data.
// - Reload bit starts a soft reset from the store if select pin low; self-clears.
// - Control bit 0 lifts store write protection; reset value 0 protects.
// - Writing 1 to store command bit 0 copies buffer bank into the store.
// - Store command bit returns to 0 by itself when the write finishes.
// - Transfer follows segment list of start address, count and opcodes.
// - Default segment list covers all registers and commits after loading.
// - Commit request copies buffer into active registers on the second edge after the write; self-clears.
module csc_ctrl (
	input  wire        clk,
	input  wire        resetn,
	input  wire [11:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        store_select_n,
	input  wire        status_route_busy,
	input  wire        status_alt,
	output wire        status_pin,
	output reg         soft_reset,
	output reg         update_active,
	output wire [11:0] buf_raddr,
	input  wire [7:0]  buf_rdata,
	output wire        buf_we,
	output wire [11:0] buf_waddr,
	output wire [7:0]  buf_wdata,
	output wire        nv_req,
	output wire        nv_we,
	output wire [9:0]  nv_addr,
	output wire [7:0]  nv_wdata,
	input  wire [7:0]  nv_rdata,
	input  wire        nv_ack
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [`CSC_SEG_BITS-1:0] seg_list;
	reg                      wr_enable;
	reg                      store_cmd;
	reg                      commit_req;
	reg                      sel_meta;
	reg                      sel_sync;
	reg  [1:0]               boot_cnt;
	reg                      boot_pending;
	wire                     busy;
	wire                     done;
	wire                     err;
	wire                     eng_commit;
	wire                     wr_store;
	wire                     wr_reload;
	wire                     start_save;
	wire                     start_load;
	wire                     boot_load;
	wire                     seg_hit;
	wire [4:0]               seg_idx;

	// ****************************************************************
	// Decode
	// ****************************************************************

	// Command strobes; a store under protection or during a transfer is dropped.
	assign wr_store   = reg_wr & (reg_addr == `CSC_ADDR_STORE_CMD) & reg_wdata[`CSC_BIT_STORE_GO];
	assign start_save = wr_store & wr_enable & ~busy;
	assign wr_reload  = reg_wr & (reg_addr == `CSC_ADDR_RELOAD) & reg_wdata[`CSC_BIT_RELOAD];
	assign boot_load  = boot_pending & (boot_cnt == `CSC_BOOT_WAIT) & ~sel_sync;
	assign start_load = ((wr_reload & ~sel_sync) | boot_load) & ~busy & ~start_save;
	assign seg_hit    = (reg_addr >= `CSC_ADDR_SEG_FIRST) & (reg_addr <= `CSC_ADDR_SEG_LAST);
	assign seg_idx    = reg_addr[4:0];
	assign status_pin = status_route_busy ? busy : status_alt;

	// ****************************************************************
	// Pin synchroniser and power-up load
	// ****************************************************************

	// The select pin is asynchronous; only the second flop is looked at.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_meta <= 1'b1;
			sel_sync <= 1'b1;
		end else begin
			sel_meta <= store_select_n;
			sel_sync <= sel_meta;
		end
	end

	// After reset wait for the synchroniser to settle, then load once if selected.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			boot_cnt     <= 2'd0;
			boot_pending <= 1'b1;
		end else if (boot_pending) begin
			if (boot_cnt == `CSC_BOOT_WAIT)
				boot_pending <= busy;
			else
				boot_cnt <= boot_cnt + 2'd1;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Writable state. The store command bit stands until the engine reports done.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seg_list   <= `CSC_SEG_DEFAULT;
			wr_enable  <= `CSC_RST_WR_ENABLE;
			store_cmd  <= 1'b0;
			commit_req <= 1'b0;
		end else begin
			if (reg_wr & seg_hit & ~busy)
				seg_list[seg_idx*8 +: 8] <= reg_wdata;
			if (reg_wr & (reg_addr == `CSC_ADDR_RELOAD))
				wr_enable <= reg_wdata[`CSC_BIT_WR_ENABLE];
			if (start_save)
				store_cmd <= 1'b1;
			else if (done)
				store_cmd <= 1'b0;
			commit_req <= reg_wr & (reg_addr == `CSC_ADDR_COMMIT)
				& reg_wdata[`CSC_BIT_COMMIT];
		end
	end

	// Pulses out: the soft reset marks a reload, the update copies buffer to active.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			soft_reset    <= 1'b0;
			update_active <= 1'b0;
		end else begin
			soft_reset    <= start_load & ~boot_load;
			update_active <= commit_req | eng_commit;
		end
	end

	// Registered read port; reload and commit bits read 0, the store command bit reads 1 until done, unmapped addresses read 0.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (seg_hit)
				reg_rdata <= seg_list[seg_idx*8 +: 8];
			else case (reg_addr)
			`CSC_ADDR_STATUS:    reg_rdata <= {7'h00, busy};
			`CSC_ADDR_ERROR:     reg_rdata <= {7'h00, err};
			`CSC_ADDR_RELOAD:    reg_rdata <= {7'h00, wr_enable};
			`CSC_ADDR_STORE_CMD: reg_rdata <= {7'h00, store_cmd};
			default:             reg_rdata <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Transfer engine
	// ****************************************************************
	csc_xfer u_xfer (
		.clk       (clk),
		.resetn    (resetn),
		.start     (start_save | start_load),
		.save      (start_save),
		.seg_list  (seg_list),
		.busy      (busy),
		.done      (done),
		.err       (err),
		.commit    (eng_commit),
		.buf_raddr (buf_raddr),
		.buf_rdata (buf_rdata),
		.buf_we    (buf_we),
		.buf_waddr (buf_waddr),
		.buf_wdata (buf_wdata),
		.nv_req    (nv_req),
		.nv_we     (nv_we),
		.nv_addr   (nv_addr),
		.nv_wdata  (nv_wdata),
		.nv_rdata  (nv_rdata),
		.nv_ack    (nv_ack)
	);

endmodule

// ==== tb/csc_ctrl_assertions.sv ====
// Port checker of the configuration store controller.
`timescale 1ns/1ns
module csc_ctrl_chk (
	input wire        clk,
	input wire        resetn,
	input wire [11:0] reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        store_select_n,
	input wire        status_route_busy,
	input wire        status_alt,
	input wire        status_pin,
	input wire        soft_reset,
	input wire        update_active,
	input wire        buf_we,
	input wire [7:0]  buf_wdata,
	input wire        nv_req,
	input wire        nv_we,
	input wire [9:0]  nv_addr,
	input wire [7:0]  nv_wdata,
	input wire [7:0]  nv_rdata,
	input wire        nv_ack
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
reg wen;
// Shadow of the write enable, because a save is only legal while it is set.
always @(posedge clk or negedge resetn)
	if (!resetn)
		wen <= 1'b0;
	else if (reg_wr && reg_addr == 12'hB02)
		wen <= reg_wdata[0];
alt_route_a: assert property (!status_route_busy |-> status_pin == status_alt)
	else $error("status pin not alternate");
busy_pin_a: assert property (status_route_busy && nv_req |-> status_pin)
	else $error("busy not on status pin");
save_start_a: assert property (reg_wr && reg_addr == 12'hB03 && reg_wdata[0] && wen
	&& status_route_busy && !status_pin |-> ##2 nv_req && nv_we) else $error("save not started");
save_protect_a: assert property (reg_wr && reg_addr == 12'hB03 && !wen
	&& status_route_busy && !status_pin |=> !status_pin [*3]) else $error("protected save ran");
reload_cause_a: assert property (soft_reset |-> $past(reg_wr) && $past(reg_addr) == 12'hB02
	&& $past(reg_wdata[1]) ##1 !soft_reset) else $error("soft reset without request");
reload_pin_a: assert property (store_select_n && $past(store_select_n)
	&& $past(store_select_n, 2) && $past(store_select_n, 3) |-> !soft_reset)
	else $error("soft reset with pin high");
commit_pulse_a: assert property (reg_wr && reg_addr == 12'h232 && reg_wdata[0]
	|-> ##2 update_active ##1 !update_active) else $error("commit pulse wrong");
store_hold_a: assert property (nv_req && !nv_ack |=> nv_req && $stable(nv_addr)
	&& $stable(nv_we) && $stable(nv_wdata)) else $error("store request not held");
load_data_a: assert property (buf_we |-> $past(nv_req) && $past(nv_ack) && !$past(nv_we)
	&& buf_wdata == $past(nv_rdata)) else $error("buffer write without store read");
endmodule

bind csc_ctrl csc_ctrl_chk chk_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.store_select_n, .status_route_busy, .status_alt, .status_pin, .soft_reset,
	.update_active, .buf_we, .buf_wdata, .nv_req, .nv_we, .nv_addr, .nv_wdata,
	.nv_rdata, .nv_ack);

// ==== tb/csc_store_model.sv ====
// Behavioural model of the nonvolatile store behind the controller.
`timescale 1ns/1ns
module csc_store_model (
	input  wire       clk,
	input  wire       resetn,
	input  wire       nv_req,
	input  wire       nv_we,
	input  wire [9:0] nv_addr,
	input  wire [7:0] nv_wdata,
	output reg  [7:0] nv_rdata,
	output reg        nv_ack,
	input  wire [1:0] lat,
	input  wire       bad_en
);
reg [7:0] mem [0:1023];
reg [1:0] wait_cnt;
// Answers after lat idle cycles; outside an answer the read data toggles so stale data shows.
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		nv_ack <= 1'b0;
		wait_cnt <= 2'h0;
		nv_rdata <= 8'hA5;
	end else if (nv_req && !nv_ack && wait_cnt >= lat) begin
		nv_ack <= 1'b1;
		wait_cnt <= 2'h0;
		if (nv_we)
			mem[nv_addr] <= nv_wdata;
		nv_rdata <= mem[nv_addr] ^ {7'h00, bad_en && nv_addr == 10'h005};
	end else begin
		nv_ack <= 1'b0;
		wait_cnt <= nv_req ? wait_cnt + 2'h1 : 2'h0;
		nv_rdata <= ~nv_rdata;
	end
end
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench of the configuration store controller.
`timescale 1ns/1ns
module testbench;
reg         clk, resetn, reg_wr, reg_rd, store_select_n, status_route_busy, status_alt, bad_en;
reg  [11:0] reg_addr;
reg  [7:0]  reg_wdata, e, sum;
reg  [1:0]  lat;
wire [7:0]  reg_rdata, buf_rdata, buf_wdata, nv_wdata, nv_rdata;
wire [11:0] buf_raddr, buf_waddr;
wire [9:0]  nv_addr;
wire        status_pin, soft_reset, update_active, buf_we, nv_req, nv_we, nv_ack;
integer     miscompares, check_count, cycles, n_buf, n_upd, n_soft, i, k;
// The bank pattern depends on the address, so misplaced bytes are caught.
assign buf_rdata = buf_raddr[7:0] ^ 8'h5A;
csc_ctrl dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_select_n(store_select_n),
	.status_route_busy(status_route_busy), .status_alt(status_alt), .status_pin(status_pin),
	.soft_reset(soft_reset), .update_active(update_active), .buf_raddr(buf_raddr),
	.buf_rdata(buf_rdata), .buf_we(buf_we), .buf_waddr(buf_waddr), .buf_wdata(buf_wdata),
	.nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
	.nv_rdata(nv_rdata), .nv_ack(nv_ack));
csc_store_model store_u (.clk(clk), .resetn(resetn), .nv_req(nv_req), .nv_we(nv_we),
	.nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_ack(nv_ack),
	.lat(lat), .bad_en(bad_en));
// Free running clock.
initial begin
	clk = 1'b0;
	forever #50 clk = ~clk;
end
task chk(input [7:0] got, input [7:0] exp);
begin
	check_count = check_count + 1;
	if (got !== exp) begin
		miscompares = miscompares + 1;
		$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
	end
end
endtask
task conclude;
begin
	$display("Checks %0d, mismatches %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
end
endtask
task wr(input [11:0] a, input [7:0] d);
begin
	@(posedge clk);
	reg_wr <= 1'b1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clk);
	reg_wr <= 1'b0;
end
endtask
task rdchk(input [11:0] a, input [7:0] d);
begin
	@(posedge clk);
	reg_rd <= 1'b1;
	reg_addr <= a;
	@(posedge clk);
	reg_rd <= 1'b0;
	#1 chk(reg_rdata, d);
end
endtask
// Waits on the routed busy flag; the cycle ceiling below catches a hang.
task wait_idle;
begin
	repeat (2) @(posedge clk);
	while (status_pin !== 1'b0) @(posedge clk);
end
endtask
// Pulse counters, loaded byte checks and the run ceiling.
always @(posedge clk) begin
	cycles = cycles + 1;
	if (buf_we) n_buf = n_buf + 1;
	if (buf_we && !bad_en) chk(buf_wdata, buf_waddr[7:0] ^ 8'h5A);
	if (update_active) n_upd = n_upd + 1;
	if (soft_reset) n_soft = n_soft + 1;
	if (cycles == 20000) begin
		miscompares = miscompares + 1;
		conclude;
	end
end
// Main sequence.
initial begin
	{miscompares, check_count, cycles, n_buf, n_upd, n_soft} = 0;
	{resetn, reg_wr, reg_rd, reg_addr, reg_wdata, status_alt, bad_en} = 0;
	{store_select_n, status_route_busy, lat} = 4'hF;
	repeat (10) @(posedge clk);
	resetn <= 1'b1;
	rdchk(12'hB00, 8'h00);
	rdchk(12'hB01, 8'h00);
	rdchk(12'hB02, 8'h00);
	rdchk(12'h7FF, 8'h00);
	rdchk(12'hA00, 8'h1F);
	rdchk(12'hA0C, 8'hFE);
	wr(12'hB03, 8'h01);
	rdchk(12'hB03, 8'h00);
	rdchk(12'hB00, 8'h00);
	wr(12'hB02, 8'h01);
	wr(12'hB03, 8'h01);
	rdchk(12'hB03, 8'h01);
	rdchk(12'hB00, 8'h01);
	wait_idle;
	rdchk(12'hB03, 8'h00);
	rdchk(12'hB00, 8'h00);
	sum = 8'h00;
	for (i = 0; i < 84; i = i + 1) begin
		k = i < 32 ? i : i < 48 ? i + 208 : i < 80 ? i + 96 : i - 32;
		e = k[7:0] ^ 8'h5A;
		sum = sum ^ e;
		chk(store_u.mem[i], e);
	end
	chk(store_u.mem[84], sum);
	@(posedge clk);
	store_select_n <= 1'b0;
	repeat (4) @(posedge clk);
	wr(12'hB02, 8'h02);
	wait_idle;
	chk(n_soft[7:0], 8'h01);
	chk(n_buf[7:0], 8'd84);
	chk(n_upd[7:0], 8'h01);
	rdchk(12'hB01, 8'h00);
	rdchk(12'hB02, 8'h00);
	@(posedge clk);
	bad_en <= 1'b1;
	wr(12'hB02, 8'h02);
	wait_idle;
	rdchk(12'hB01, 8'h01);
	@(posedge clk);
	bad_en <= 1'b0;
	k = n_upd;
	wr(12'h232, 8'h01);
	rdchk(12'h232, 8'h00);
	chk(n_upd[7:0], k[7:0] + 8'h01);
	@(posedge clk);
	store_select_n <= 1'b1;
	repeat (4) @(posedge clk);
	k = n_soft;
	wr(12'hB02, 8'h02);
	rdchk(12'hB00, 8'h00);
	chk(n_soft[7:0], k[7:0]);
	@(posedge clk);
	status_route_busy <= 1'b0;
	status_alt <= 1'b1;
	@(posedge clk);
	#1 chk({7'h00, status_pin}, 8'h01);
	conclude;
end
endmodule
